/* File: hw/rhs_stall_ctrl.sv */
// Read-after-write hazard detector and stall sequencer for a 16-bit core with one-deep prefetch.
// Assumes decode presents the executing and prefetched instructions on the same clock,
// and that instr_adv pulses once at each instruction boundary while the core is not held.
`timescale 1ns/1ps

module rhs_stall_ctrl (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire rhs_pkg::rhs_cur_t cur,
    input  wire rhs_pkg::rhs_pf_t  pf,
    input  wire logic              instr_adv,
    input  wire logic              irq_take,
    input  wire logic              rpt_active,
    input  wire logic [15:0]       core_control_reg,
    output logic                   stall,
    output logic                   pc_hold,
    output logic                   fetch_hold,
    output logic                   ds_idle,
    output logic                   win_wait,
    output logic                   exc_two_cycle
);
    import rhs_pkg::*;

    // Pointer lands on the data-space word where working register idx is mapped
    function automatic logic maps_to_wreg(input logic [15:0] ptr, input logic [3:0] idx);
        logic [15:0] addr;
        addr = RHS_WREG_MAP_BASE + {11'h000, idx, 1'b0};
        return ptr == addr;
    endfunction

    // Source computes an address from its register
    function automatic logic is_indirect(input rhs_mode_t m);
        return (m == RHS_MODE_IND) || (m == RHS_MODE_IND_MOD);
    endfunction

    // Flow-change classes that perform no data write
    function automatic logic is_read_only(input rhs_op_t o);
        return (o == RHS_OP_RETURN) || (o == RHS_OP_INT_RETURN) || (o == RHS_OP_JUMP);
    endfunction

    rhs_state_t  state;
    rhs_state_t  next_state;
    logic        win_pend;
    logic        next_win_pend;
    logic        next_stall;
    logic        next_pc_hold;
    logic        next_fetch_hold;
    logic        next_ds_idle;
    logic        next_win_wait;
    logic        next_exc_two_cycle;
    logic [2:0]  hold_run;
    logic [2:0]  next_hold_run;

    rhs_mode_t   eff_dst_mode;
    logic [3:0]  eff_dst_reg;
    rhs_mode_t   eff_src_mode;
    logic [3:0]  eff_src_reg;
    logic        same_reg;
    logic        hazard;
    logic        win_hit;
    logic        adv_ok;

    // Hazard decision for the current boundary
    always_comb begin
        eff_dst_mode = cur.dst_mode;
        eff_dst_reg  = cur.dst_reg;
        if (cur.op == RHS_OP_CALL) begin
            eff_dst_mode = RHS_MODE_IND_MOD;
            eff_dst_reg  = RHS_SP_REG;
        end
        // Repeat: the fixed prefetch is the instruction itself
        eff_src_mode = rpt_active ? cur.src_mode : pf.src_mode;
        eff_src_reg  = rpt_active ? cur.src_reg : pf.src_reg;
        same_reg     = eff_dst_reg == eff_src_reg;
        hazard       = 1'b0;
        unique case (eff_dst_mode)
            RHS_MODE_NONE: begin
                hazard = 1'b0;
            end
            RHS_MODE_DIRECT: begin
                hazard = same_reg && is_indirect(eff_src_mode);
            end
            RHS_MODE_IND: begin
                hazard = is_indirect(eff_src_mode)
                         && maps_to_wreg(cur.dst_ptr, eff_src_reg);
            end
            RHS_MODE_IND_MOD: begin
                hazard = same_reg && is_indirect(eff_src_mode);
            end
        endcase
        if (!cur.wr_changes) begin
            hazard = 1'b0;
        end
        if (!is_indirect(eff_src_mode)) begin
            hazard = 1'b0;
        end
        if (is_read_only(cur.op)) begin
            hazard = 1'b0;
        end
        // Window hit redirects the access to program space
        win_hit = core_control_reg[RHS_WIN_CTRL_BIT] && pf.ea_valid
                  && (pf.src_ea >= RHS_WIN_BASE);
        adv_ok  = (state == RHS_ST_RUN) && instr_adv;
    end

    // Sequencer: stall cycle first, then the program-space wait cycles
    always_comb begin
        next_state         = state;
        next_win_pend      = win_pend;
        next_exc_two_cycle = (state == RHS_ST_STALL) && irq_take;
        unique case (state)
            RHS_ST_RUN: begin
                if (adv_ok) begin
                    next_win_pend = win_hit;
                    // Interrupt on the first instruction: exception covers the write
                    if (hazard && !irq_take) begin
                        next_state = RHS_ST_STALL;
                    end else if (win_hit) begin
                        next_state = RHS_ST_WIN_A;
                    end
                end
            end
            RHS_ST_STALL: begin
                next_state    = win_pend ? RHS_ST_WIN_A : RHS_ST_RUN;
                next_win_pend = 1'b0;
            end
            RHS_ST_WIN_A: begin
                next_state    = RHS_ST_WIN_B;
                next_win_pend = 1'b0;
            end
            RHS_ST_WIN_B: begin
                next_state = RHS_ST_RUN;
            end
        endcase
        next_stall      = next_state == RHS_ST_STALL;
        next_ds_idle    = next_stall;
        next_pc_hold    = next_state != RHS_ST_RUN;
        next_fetch_hold = next_state != RHS_ST_RUN;
        next_win_wait   = (next_state == RHS_ST_WIN_A) || (next_state == RHS_ST_WIN_B);
    end

    // Consecutive held cycles, saturating; watched by the hold limit check
    always_comb begin
        next_hold_run = hold_run;
        if (!pc_hold) begin
            next_hold_run = 3'h0;
        end else if (hold_run != 3'h7) begin
            next_hold_run = hold_run + 3'h1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hold_run <= 3'h0;
        end else begin
            hold_run <= next_hold_run;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state         <= RHS_ST_RUN;
            win_pend      <= 1'b0;
            stall         <= 1'b0;
            pc_hold       <= 1'b0;
            fetch_hold    <= 1'b0;
            ds_idle       <= 1'b0;
            win_wait      <= 1'b0;
            exc_two_cycle <= 1'b0;
        end else begin
            state         <= next_state;
            win_pend      <= next_win_pend;
            stall         <= next_stall;
            pc_hold       <= next_pc_hold;
            fetch_hold    <= next_fetch_hold;
            ds_idle       <= next_ds_idle;
            win_wait      <= next_win_wait;
            exc_two_cycle <= next_exc_two_cycle;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_hazard_stalls: assert property (adv_ok && hazard && !irq_take |=> stall)
        else $error("hazard at boundary gave no stall");
    a_unchanged_free: assert property (adv_ok && !cur.wr_changes |=> !stall)
        else $error("stall on unchanged write");
    a_direct_src_free: assert property (adv_ok && !rpt_active
                                        && pf.src_mode == RHS_MODE_DIRECT |=> !stall)
        else $error("stall on direct source");
    a_stall_single: assert property ($rose(stall) |=> !stall)
        else $error("stall longer than one cycle");
    a_stall_holds: assert property (stall |-> pc_hold && fetch_hold && ds_idle)
        else $error("stall without holds");
    a_irq_first: assert property (adv_ok && irq_take |=> !stall)
        else $error("stall kept after interrupt on first");
    a_irq_second: assert property (stall && irq_take |=> exc_two_cycle && !stall)
        else $error("interrupt during stall not two-cycle");
    a_return_free: assert property (adv_ok && (cur.op == RHS_OP_RETURN
                                    || cur.op == RHS_OP_JUMP) |=> !stall)
        else $error("return or jump stalled");
    a_call_sp: assert property (adv_ok && cur.op == RHS_OP_CALL && cur.wr_changes
                                && !irq_take && !rpt_active && pf.src_reg == RHS_SP_REG
                                && pf.src_mode == RHS_MODE_IND |=> stall)
        else $error("call did not stall on stack pointer use");
    a_win_two: assert property ($rose(win_wait) |-> win_wait ##1 win_wait ##1 !win_wait)
        else $error("window wait not two cycles");
    a_stall_then_win: assert property (adv_ok && hazard && !irq_take && win_hit
                                       |=> stall ##1 win_wait ##1 win_wait ##1 !pc_hold)
        else $error("stall and window wait not stacked");

    a_stall_after_adv: assert property ($rose(stall) |-> $past(adv_ok))
        else $error("stall without a preceding boundary");

    a_direct_direct: assert property (adv_ok && !rpt_active && cur.dst_mode == RHS_MODE_DIRECT
                                      && pf.src_mode == RHS_MODE_DIRECT |=> !stall)
        else $error("direct pair stalled");

    a_direct_ind: assert property (adv_ok && !irq_take && !rpt_active
                                   && cur.op == RHS_OP_PLAIN && cur.wr_changes
                                   && cur.dst_mode == RHS_MODE_DIRECT
                                   && cur.dst_reg == pf.src_reg
                                   && is_indirect(pf.src_mode) |=> stall)
        else $error("direct write then indirect read did not stall");

    a_ind_plain_free: assert property (adv_ok && !rpt_active && cur.op == RHS_OP_PLAIN
                                       && cur.dst_mode == RHS_MODE_IND
                                       && !maps_to_wreg(cur.dst_ptr, pf.src_reg)
                                       |=> !stall)
        else $error("plain indirect write stalled");

    a_ind_self_map: assert property (adv_ok && !irq_take && !rpt_active
                                     && cur.op == RHS_OP_PLAIN && cur.wr_changes
                                     && cur.dst_mode == RHS_MODE_IND
                                     && maps_to_wreg(cur.dst_ptr, pf.src_reg)
                                     && is_indirect(pf.src_mode) |=> stall)
        else $error("self-mapped pointer write did not stall");

    a_mod_stall: assert property (adv_ok && !irq_take && !rpt_active
                                  && cur.op == RHS_OP_PLAIN && cur.wr_changes
                                  && cur.dst_mode == RHS_MODE_IND_MOD
                                  && cur.dst_reg == pf.src_reg
                                  && is_indirect(pf.src_mode) |=> stall)
        else $error("modified pointer write did not stall");

    a_flow_free: assert property (adv_ok && is_read_only(cur.op) |=> !stall)
        else $error("read-only flow change stalled");

    a_rpt_own_src: assert property (adv_ok && rpt_active
                                    && !is_indirect(cur.src_mode) |=> !stall)
        else $error("repeat stalled on prefetch source");

    a_rpt_self: assert property (adv_ok && !irq_take && rpt_active
                                 && cur.op == RHS_OP_PLAIN && cur.wr_changes
                                 && cur.dst_mode == RHS_MODE_DIRECT
                                 && cur.dst_reg == cur.src_reg
                                 && is_indirect(cur.src_mode) |=> stall)
        else $error("repeat self hazard did not stall");

    a_window_off: assert property (adv_ok && !core_control_reg[RHS_WIN_CTRL_BIT]
                                   |=> !win_wait)
        else $error("window wait with visibility off");

    a_window_hit: assert property (adv_ok && win_hit && !(hazard && !irq_take)
                                   |=> win_wait)
        else $error("window hit without wait");

    a_ds_idle_stall: assert property (ds_idle |-> stall)
        else $error("data space idle outside stall");

    a_hold_pair: assert property (fetch_hold == pc_hold)
        else $error("fetch and counter holds differ");

    a_stall_release: assert property (stall |=> !ds_idle)
        else $error("data space idle beyond one cycle");

    a_hold_limit: assert property (hold_run <= RHS_HOLD_MAX)
        else $error("hold longer than stall plus window");

    a_exc_pulse: assert property (exc_two_cycle |=> !exc_two_cycle)
        else $error("exception timing pulse too long");

    c_plain_stall: cover property (adv_ok && hazard ##1 stall);
    c_irq_stall:   cover property (stall && irq_take);
    c_win_stack:   cover property (stall ##1 win_wait);
    c_rpt_stall:   cover property (adv_ok && rpt_active && hazard);
    c_call_stall:  cover property (adv_ok && cur.op == RHS_OP_CALL ##1 stall);

endmodule

/* File: hw/rhs_pkg.sv */
// Package for the read-after-write stall controller: constants, modes, states, carriers.
// Assumes one instruction-cycle clock shared by decode, prefetch and the data space.
package rhs_pkg;

    localparam logic [3:0]  RHS_SP_REG         = 4'hf;
    localparam int          RHS_WIN_CTRL_BIT   = 2;
    localparam logic [15:0] RHS_WIN_BASE       = 16'h8000;
    localparam logic [15:0] RHS_WREG_MAP_BASE  = 16'h0000;
    localparam int          RHS_STALL_CYCLES   = 1;
    localparam int          RHS_WIN_EXTRA      = 2;
    localparam int          RHS_HOLD_MAX       = RHS_STALL_CYCLES + RHS_WIN_EXTRA;

    typedef enum logic [1:0] {
        RHS_MODE_NONE    = 2'b00,
        RHS_MODE_DIRECT  = 2'b01,
        RHS_MODE_IND     = 2'b10,
        RHS_MODE_IND_MOD = 2'b11
    } rhs_mode_t;

    typedef enum logic [2:0] {
        RHS_OP_PLAIN  = 3'b000,
        RHS_OP_CALL   = 3'b001,
        RHS_OP_RETURN = 3'b010,
        RHS_OP_INT_RETURN = 3'b011,
        RHS_OP_LIT_RETURN = 3'b100,
        RHS_OP_JUMP   = 3'b101
    } rhs_op_t;

    typedef enum logic [1:0] {
        RHS_ST_RUN   = 2'b00,
        RHS_ST_STALL = 2'b01,
        RHS_ST_WIN_A = 2'b10,
        RHS_ST_WIN_B = 2'b11
    } rhs_state_t;

    // Executing instruction: its write and its own source
    typedef struct packed {
        rhs_op_t     op;
        rhs_mode_t   dst_mode;
        logic [3:0]  dst_reg;
        logic [15:0] dst_ptr;
        logic        wr_changes;
        rhs_mode_t   src_mode;
        logic [3:0]  src_reg;
    } rhs_cur_t;

    // Prefetched instruction: its source and effective address
    typedef struct packed {
        rhs_mode_t   src_mode;
        logic [3:0]  src_reg;
        logic        ea_valid;
        logic [15:0] src_ea;
    } rhs_pf_t;

endpackage

/* File: tb/rhs_fetch_model.sv */
// Prefetch unit and data-space model: counts fetches and data-space accesses.
// Assumes the hold outputs of the stall controller are registered on ref_clk.
`timescale 1ns/1ps
module rhs_fetch_model (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        fetch_hold,
    input  wire logic        ds_idle,
    output logic [15:0]      fetch_cnt,
    output logic [15:0]      ds_cnt
);
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fetch_cnt <= 16'h0000;
            ds_cnt    <= 16'h0000;
        end else begin
            if (!fetch_hold) fetch_cnt <= fetch_cnt + 16'h0001;
            if (!ds_idle) ds_cnt <= ds_cnt + 16'h0001;
        end
    end
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the stall controller, one boundary per case.
// Assumes a 10 MHz instruction clock; inputs change on the falling edge.
`timescale 1ns/1ps
module tb_top;
    import rhs_pkg::*;
    localparam rhs_mode_t   N = RHS_MODE_NONE, D = RHS_MODE_DIRECT;
    localparam rhs_mode_t   I = RHS_MODE_IND, M = RHS_MODE_IND_MOD;
    localparam rhs_op_t     P = RHS_OP_PLAIN, C = RHS_OP_CALL, R = RHS_OP_RETURN;
    localparam rhs_op_t     F = RHS_OP_INT_RETURN, L = RHS_OP_LIT_RETURN, J = RHS_OP_JUMP;
    localparam logic [15:0] EA = 16'h0100, PW = 16'h8000, MW = 16'h0004;
    localparam logic [3:0]  R2 = 4'h2, R5 = 4'h5;
    logic        ref_clk, rst, instr_adv, irq_take, rpt_active;
    logic        stall, pc_hold, fetch_hold, ds_idle, win_wait, exc_two_cycle;
    logic [15:0] core_control_reg, fetch_cnt, ds_cnt;
    rhs_cur_t    cur;
    rhs_pf_t     pf;
    int          err_count, n_checks, cyc, tn;

    rhs_stall_ctrl rhs_stall_ctrl_i (.ref_clk(ref_clk), .rst(rst), .cur(cur), .pf(pf),
        .instr_adv(instr_adv), .irq_take(irq_take), .rpt_active(rpt_active),
        .core_control_reg(core_control_reg), .stall(stall), .pc_hold(pc_hold),
        .fetch_hold(fetch_hold), .ds_idle(ds_idle), .win_wait(win_wait),
        .exc_two_cycle(exc_two_cycle));
    rhs_fetch_model rhs_fetch_model_i (.ref_clk(ref_clk), .rst(rst), .fetch_hold(fetch_hold),
        .ds_idle(ds_idle), .fetch_cnt(fetch_cnt), .ds_cnt(ds_cnt));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    function automatic rhs_cur_t cu(rhs_op_t o, rhs_mode_t m, logic [3:0] r, logic [15:0] p,
                                    logic w, rhs_mode_t sm);
        return '{o, m, r, p, w, sm, r};
    endfunction

    function automatic rhs_pf_t pp(rhs_mode_t m, logic [3:0] r, logic [15:0] ea);
        return '{m, r, 1'b1, ea};
    endfunction

    task automatic chk(input logic [15:0] a, input logic [15:0] e);
        n_checks++;
        if (a !== e) begin
            err_count++;
            $display("Error t=%0t got %h exp %h", $time, a, e);
        end
    endtask

    task end_of_test;
        $display("Checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // One boundary, then four cycles of expected hold pattern and counts
    task automatic run(input rhs_cur_t c, input rhs_pf_t p, input logic irq, input logic rpt,
                       input logic win, input logic s, input logic w, input logic irq2);
        logic [15:0] f0, d0;
        logic        es, ew;
        @(negedge ref_clk);
        cur = c;
        pf = p;
        irq_take = irq;
        rpt_active = rpt;
        core_control_reg = {13'h0000, win, 2'h0};
        instr_adv = 1'b1;
        f0 = fetch_cnt;
        d0 = ds_cnt;
        for (int k = 1; k <= 4; k++) begin
            @(negedge ref_clk);
            instr_adv = 1'b0;
            irq_take = irq2 && k == 1;
            es = s && k == 1;
            ew = w && (k == 1 + s || k == 2 + s);
            chk(stall, es);
            chk(win_wait, ew);
            chk(pc_hold, es | ew);
            chk(fetch_hold, es | ew);
            chk(ds_idle, es);
            chk(exc_two_cycle, irq2 && k == 2);
        end
        chk(fetch_cnt - f0, 16'(4 - s - 2 * w));
        chk(ds_cnt - d0, 16'(4 - s));
        tn++;
        $display("Case %0d done", tn);
    endtask

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 1000) begin
            err_count++;
            end_of_test;
        end
    end

    initial begin
        rst = 1'b1;
        instr_adv = 1'b0;
        irq_take = 1'b0;
        rpt_active = 1'b0;
        core_control_reg = 16'h0000;
        cur = '0;
        pf = '0;
        repeat (8) @(negedge ref_clk);
        rst = 1'b0;
        run(cu(P, D, R2, '0, '1, N), pp(D, R2, EA), 0, 0, 0, 0, 0, 0);
        run(cu(P, D, R2, '0, '1, N), pp(I, R2, EA), 0, 0, 0, 1, 0, 0);
        run(cu(P, D, R2, '0, '1, N), pp(M, R2, EA), 0, 0, 0, 1, 0, 0);
        run(cu(P, D, R2, '0, '1, N), pp(I, R5, EA), 0, 0, 0, 0, 0, 0);
        run(cu(P, I, R2, EA, '1, N), pp(M, R2, EA), 0, 0, 0, 0, 0, 0);
        run(cu(P, I, R2, MW, '1, N), pp(I, R2, EA), 0, 0, 0, 1, 0, 0);
        run(cu(P, I, R2, MW, '1, N), pp(D, R2, EA), 0, 0, 0, 0, 0, 0);
        run(cu(P, M, R2, '0, '1, N), pp(I, R2, EA), 0, 0, 0, 1, 0, 0);
        run(cu(P, M, R2, '0, '1, N), pp(M, R2, EA), 0, 0, 0, 1, 0, 0);
        run(cu(P, M, R2, '0, '1, N), pp(D, R2, EA), 0, 0, 0, 0, 0, 0);
        run(cu(P, D, R2, '0, '0, N), pp(I, R2, EA), 0, 0, 0, 0, 0, 0);
        run(cu(C, N, 4'h0, '0, '1, N), pp(I, RHS_SP_REG, EA), 0, 0, 0, 1, 0, 0);
        run(cu(R, D, R2, '0, '1, N), pp(I, R2, EA), 0, 0, 0, 0, 0, 0);
        run(cu(F, D, R2, '0, '1, N), pp(I, R2, EA), 0, 0, 0, 0, 0, 0);
        run(cu(L, D, R2, '0, '1, N), pp(I, R2, EA), 0, 0, 0, 1, 0, 0);
        run(cu(J, D, R2, '0, '1, N), pp(I, R2, EA), 0, 0, 0, 0, 0, 0);
        run(cu(P, D, R2, '0, '1, N), pp(I, R2, EA), 1, 0, 0, 0, 0, 0);
        run(cu(P, D, R2, '0, '1, N), pp(I, R2, EA), 0, 0, 0, 1, 0, 1);
        run(cu(P, D, R2, '0, '1, I), pp(D, R5, EA), 0, 1, 0, 1, 0, 0);
        run(cu(P, D, R2, '0, '1, N), pp(I, R2, EA), 0, 1, 0, 0, 0, 0);
        run(cu(P, D, R2, '0, '1, N), pp(D, R5, PW), 0, 0, 1, 0, 1, 0);
        run(cu(P, D, R2, '0, '1, N), pp(D, R5, PW), 0, 0, 0, 0, 0, 0);
        run(cu(P, D, R2, '0, '1, N), pp(D, R5, 16'h7ffe), 0, 0, 1, 0, 0, 0);
        run(cu(P, M, R2, '0, '1, N), pp(I, R2, PW), 0, 0, 1, 1, 1, 0);
        end_of_test;
    end
endmodule
